// ===== src/optstat_defines.vh
// Constants of the option status and unlock key block: register offsets,
// field positions, key words and the fixed option status bits.
// Assumes inclusion by bare name from design files compiled after it.
`ifndef OPTSTAT_DEFINES_VH
`define OPTSTAT_DEFINES_VH

// ==========================================================================
// Register byte addresses
`define OFS_OPTION_BYTE_STATUS  8'h1c
`define OFS_WRITE_PROTECT_STAT  8'h20
`define OFS_FAST_MODE_KEY       8'h24
`define OFS_BOOT_AREA_KEY       8'h28
`define OFS_LOCK_STATUS         8'h2c
`define OFS_IRQ_STATUS          8'h30
`define OFS_IRQ_MASK            8'h34

// ==========================================================================
// Key words
`define FIRST_UNLOCK_WORD       32'h45670123
`define SECOND_UNLOCK_WORD      32'hcdef89ab

// ==========================================================================
// Option status fields
`define OBS_BOOT_BIT            7
`define OBS_RSTDLY_HI           6
`define OBS_RSTDLY_LO           5
`define OBS_STBY_BIT            4
`define OBS_RDP_BIT             1
`define OBS_ERR_BIT             0
`define OBS_FIXED_ONES          2'h3
`define OBS_RESERVED_HI         6'h00
`define OBS_RESERVED_MID        2'h0
`define RDP_OPEN_CODE           8'ha5

// ==========================================================================
// Lock status bits and interrupt events
`define LCK_FAST_BIT            0
`define LCK_BOOT_BIT            1
`define LCK_FAST_DEAD_BIT       2
`define LCK_BOOT_DEAD_BIT       3
`define EVT_FAST_UNLOCK         0
`define EVT_BOOT_UNLOCK         1
`define EVT_FAST_ERROR          2
`define EVT_BOOT_ERROR          3
`define EVT_OPT_ERROR           4
`define EVT_WIDTH               5

// ==========================================================================
// Option byte load sequencing and AXI response codes
`define LOAD_CYCLES             4'h4
`define AXI_OKAY                2'h0
`define AXI_SLVERR              2'h2

`endif

// ===== src/key_sequencer.v
// One two-word unlock sequencer: watches writes to its key register.
// Assumes key_wr is a one-cycle pulse on aclk with key_data stable.
`timescale 1ns/1ps
`include "optstat_defines.vh"

module key_sequencer (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire        key_wr,
    input  wire [31:0] key_data,
    input  wire        relock,
    output reg         locked_r,
    output reg         dead_r,
    output reg         unlock_evt_r,
    output reg         error_evt_r
);

// ==========================================================================
// Sequence state
localparam ST_IDLE  = 2'h0;
localparam ST_FIRST = 2'h1;
localparam ST_DEAD  = 2'h2;

reg [1:0] state_r;

// First word arms, second completes; anything else kills until reset
always @(posedge aclk) begin
    if (!aresetn) begin
        state_r      <= ST_IDLE;
        locked_r     <= 1'b1;
        dead_r       <= 1'b0;
        unlock_evt_r <= 1'b0;
        error_evt_r  <= 1'b0;
    end else begin
        unlock_evt_r <= 1'b0;
        error_evt_r  <= 1'b0;
        if (relock && state_r != ST_DEAD)
            locked_r <= 1'b1;
        if (key_wr) begin
            case (state_r)
                ST_IDLE: begin
                    if (key_data == `FIRST_UNLOCK_WORD) begin
                        state_r <= ST_FIRST;
                    end else begin
                        state_r     <= ST_DEAD;
                        dead_r      <= 1'b1;
                        locked_r    <= 1'b1;
                        error_evt_r <= 1'b1;
                    end
                end
                ST_FIRST: begin
                    if (key_data == `SECOND_UNLOCK_WORD) begin
                        state_r      <= ST_IDLE;
                        locked_r     <= 1'b0;
                        unlock_evt_r <= 1'b1;
                    end else begin
                        state_r     <= ST_DEAD;
                        dead_r      <= 1'b1;
                        locked_r    <= 1'b1;
                        error_evt_r <= 1'b1;
                    end
                end
                default: begin
                    state_r <= ST_DEAD;                     // Only reset leaves here
                end
            endcase
        end
    end
end

endmodule

// ===== src/flash_option_status_keys.v
// Option status, region protect map and unlock key registers of the flash
// controller, reached over AXI4-Lite.
// Assumes option bytes and their stored complements arrive as static pins
// from the nonvolatile array, outside the aclk domain.
`timescale 1ns/1ps
`include "optstat_defines.vh"

module flash_option_status_keys #(
    parameter MAP_WIDTH = 16
) (
    input  wire                 aclk,
    input  wire                 aresetn,
    // Option byte array contents and complements
    input  wire [7:0]           nv_user_byte_high,
    input  wire [7:0]           nv_user_byte_high_n,
    input  wire [7:0]           nv_user_byte_low,
    input  wire [7:0]           nv_user_byte_low_n,
    input  wire [7:0]           nv_user_cfg,
    input  wire [7:0]           nv_user_cfg_n,
    input  wire [7:0]           nv_read_protect,
    input  wire [7:0]           nv_read_protect_n,
    input  wire [MAP_WIDTH-1:0] nv_region_map,
    input  wire [MAP_WIDTH-1:0] nv_region_map_n,
    // Relock strobes from the control register
    input  wire                 fast_relock,
    input  wire                 boot_relock,
    // AXI4-Lite slave
    input  wire [7:0]           s_axi_awaddr,
    input  wire                 s_axi_awvalid,
    output reg                  s_axi_awready,
    input  wire [31:0]          s_axi_wdata,
    input  wire [3:0]           s_axi_wstrb,
    input  wire                 s_axi_wvalid,
    output reg                  s_axi_wready,
    output reg  [1:0]           s_axi_bresp,
    output reg                  s_axi_bvalid,
    input  wire                 s_axi_bready,
    input  wire [7:0]           s_axi_araddr,
    input  wire                 s_axi_arvalid,
    output reg                  s_axi_arready,
    output reg  [31:0]          s_axi_rdata,
    output reg  [1:0]           s_axi_rresp,
    output reg                  s_axi_rvalid,
    input  wire                 s_axi_rready,
    // Lock state and interrupt
    output reg                  fast_mode_lock,
    output reg                  boot_area_lock,
    output reg                  irq
);

// ==========================================================================
// Pin synchronisers: the option array is another domain
reg [7:0]           hi_s1_r;
reg [7:0]           hi_s2_r;
reg [7:0]           hin_s1_r;
reg [7:0]           hin_s2_r;
reg [7:0]           lo_s1_r;
reg [7:0]           lo_s2_r;
reg [7:0]           lon_s1_r;
reg [7:0]           lon_s2_r;
reg [7:0]           cfg_s1_r;
reg [7:0]           cfg_s2_r;
reg [7:0]           cfgn_s1_r;
reg [7:0]           cfgn_s2_r;
reg [7:0]           rdp_s1_r;
reg [7:0]           rdp_s2_r;
reg [7:0]           rdpn_s1_r;
reg [7:0]           rdpn_s2_r;
reg [MAP_WIDTH-1:0] map_s1_r;
reg [MAP_WIDTH-1:0] map_s2_r;
reg [MAP_WIDTH-1:0] mapn_s1_r;
reg [MAP_WIDTH-1:0] mapn_s2_r;

// Two stages per input; no logic reads the first
always @(posedge aclk) begin
    hi_s1_r   <= nv_user_byte_high;
    hi_s2_r   <= hi_s1_r;
    hin_s1_r  <= nv_user_byte_high_n;
    hin_s2_r  <= hin_s1_r;
    lo_s1_r   <= nv_user_byte_low;
    lo_s2_r   <= lo_s1_r;
    lon_s1_r  <= nv_user_byte_low_n;
    lon_s2_r  <= lon_s1_r;
    cfg_s1_r  <= nv_user_cfg;
    cfg_s2_r  <= cfg_s1_r;
    cfgn_s1_r <= nv_user_cfg_n;
    cfgn_s2_r <= cfgn_s1_r;
    rdp_s1_r  <= nv_read_protect;
    rdp_s2_r  <= rdp_s1_r;
    rdpn_s1_r <= nv_read_protect_n;
    rdpn_s2_r <= rdpn_s1_r;
    map_s1_r  <= nv_region_map;
    map_s2_r  <= map_s1_r;
    mapn_s1_r <= nv_region_map_n;
    mapn_s2_r <= mapn_s1_r;
end

// ==========================================================================
// Option byte load after reset
reg [3:0]           load_cnt_r;
reg                 loaded_r;
reg [7:0]           user_byte_high_r;
reg [7:0]           user_byte_low_r;
reg                 boot_from_user_r;
reg [1:0]           reset_delay_r;
reg                 standby_entry_reset_ctl_r;
reg                 read_protect_active_r;
reg                 option_complement_error_r;
reg [MAP_WIDTH-1:0] region_protect_map_r;
reg                 opt_err_evt_r;
wire                cmp_bad;

// A byte is good only when it equals the inverse of its complement
assign cmp_bad = (hi_s2_r != ~hin_s2_r) | (lo_s2_r != ~lon_s2_r) |
                 (cfg_s2_r != ~cfgn_s2_r) | (rdp_s2_r != ~rdpn_s2_r) |
                 (map_s2_r != ~mapn_s2_r);

// Wait for the synchronisers to fill, then capture once per reset.
// Reset values: read protected, boot-from-user, region protect map cleared to all zeros.
always @(posedge aclk) begin
    if (!aresetn) begin
        load_cnt_r                <= 4'h0;
        loaded_r                  <= 1'b0;
        user_byte_high_r          <= 8'h00;
        user_byte_low_r           <= 8'h00;
        boot_from_user_r          <= 1'b1;
        reset_delay_r             <= 2'h0;
        standby_entry_reset_ctl_r <= 1'b0;
        read_protect_active_r     <= 1'b1;
        option_complement_error_r <= 1'b0;
        region_protect_map_r      <= {MAP_WIDTH{1'b0}};
        opt_err_evt_r             <= 1'b0;
    end else begin
        opt_err_evt_r <= 1'b0;
        if (!loaded_r) begin
            if (load_cnt_r == `LOAD_CYCLES) begin
                loaded_r                  <= 1'b1;
                user_byte_high_r          <= hi_s2_r;
                user_byte_low_r           <= lo_s2_r;
                boot_from_user_r          <= cfg_s2_r[`OBS_BOOT_BIT];
                reset_delay_r             <= cfg_s2_r[`OBS_RSTDLY_HI:`OBS_RSTDLY_LO];
                standby_entry_reset_ctl_r <= cfg_s2_r[`OBS_STBY_BIT];
                read_protect_active_r     <= rdp_s2_r != `RDP_OPEN_CODE;
                option_complement_error_r <= cmp_bad;
                opt_err_evt_r             <= cmp_bad;
                region_protect_map_r      <= map_s2_r;
            end else begin
                load_cnt_r <= load_cnt_r + 4'h1;
            end
        end
    end
end

// ==========================================================================
// AXI4-Lite write path: address and data taken in either order
localparam EVT_W = `EVT_WIDTH;

reg        aw_held_r;
reg [7:0]  aw_addr_r;
reg        w_held_r;
reg [31:0] w_data_r;
reg [3:0]  w_strb_r;
reg        fast_key_wr_r;
reg        boot_key_wr_r;
reg [31:0] key_data_r;
reg [EVT_W-1:0] irq_status_r;
reg [EVT_W-1:0] irq_mask_r;
wire       wr_go;
wire       full_word;
wire [EVT_W-1:0] evt;

assign wr_go     = aw_held_r && w_held_r && !s_axi_bvalid;
assign full_word = (w_strb_r == 4'hf);

// Key registers accept only full-word writes; partial ones are ignored
always @(posedge aclk) begin
    if (!aresetn) begin
        aw_held_r     <= 1'b0;
        aw_addr_r     <= 8'h00;
        w_held_r      <= 1'b0;
        w_data_r      <= 32'h00000000;
        w_strb_r      <= 4'h0;
        s_axi_awready <= 1'b0;
        s_axi_wready  <= 1'b0;
        s_axi_bvalid  <= 1'b0;
        s_axi_bresp   <= `AXI_OKAY;
        fast_key_wr_r <= 1'b0;
        boot_key_wr_r <= 1'b0;
        key_data_r    <= 32'h00000000;
        irq_mask_r    <= {EVT_W{1'b0}};
    end else begin
        fast_key_wr_r <= 1'b0;
        boot_key_wr_r <= 1'b0;
        s_axi_awready <= !aw_held_r && !s_axi_awready && s_axi_awvalid;
        s_axi_wready  <= !w_held_r && !s_axi_wready && s_axi_wvalid;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_held_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_held_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
        if (wr_go) begin
            aw_held_r    <= 1'b0;
            w_held_r     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= `AXI_OKAY;
            key_data_r   <= w_data_r;
            case (aw_addr_r)
                `OFS_FAST_MODE_KEY: fast_key_wr_r <= full_word;
                `OFS_BOOT_AREA_KEY: boot_key_wr_r <= full_word;
                `OFS_IRQ_MASK:      irq_mask_r    <= w_data_r[EVT_W-1:0];
                `OFS_IRQ_STATUS: begin
                end
                // Option byte, write protect and lock status registers are read-only: the write is dropped
                `OFS_OPTION_BYTE_STATUS, `OFS_WRITE_PROTECT_STAT,
                `OFS_LOCK_STATUS: begin
                end
                default: s_axi_bresp <= `AXI_SLVERR;
            endcase
        end
    end
end

// ==========================================================================
// Unlock sequencers
wire fast_locked;
wire fast_dead;
wire fast_unlock_evt;
wire fast_error_evt;
wire boot_locked;
wire boot_dead;
wire boot_unlock_evt;
wire boot_error_evt;

key_sequencer u_fast_seq (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .key_wr       (fast_key_wr_r),
    .key_data     (key_data_r),
    .relock       (fast_relock),
    .locked_r     (fast_locked),
    .dead_r       (fast_dead),
    .unlock_evt_r (fast_unlock_evt),
    .error_evt_r  (fast_error_evt)
);

key_sequencer u_boot_seq (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .key_wr       (boot_key_wr_r),
    .key_data     (key_data_r),
    .relock       (boot_relock),
    .locked_r     (boot_locked),
    .dead_r       (boot_dead),
    .unlock_evt_r (boot_unlock_evt),
    .error_evt_r  (boot_error_evt)
);

// ==========================================================================
// Interrupt status: sticky, write one to clear, a new event beats the clear
wire [EVT_W-1:0] clr_bits;

assign evt = {opt_err_evt_r, boot_error_evt, fast_error_evt,
              boot_unlock_evt, fast_unlock_evt};
assign clr_bits = (wr_go && aw_addr_r == `OFS_IRQ_STATUS) ?
                  (w_data_r[EVT_W-1:0] & {EVT_W{w_strb_r[0]}}) : {EVT_W{1'b0}};

always @(posedge aclk) begin
    if (!aresetn) begin
        irq_status_r   <= {EVT_W{1'b0}};
        irq            <= 1'b0;
        fast_mode_lock <= 1'b1;
        boot_area_lock <= 1'b1;
    end else begin
        irq_status_r   <= (irq_status_r & ~clr_bits) | evt;
        irq            <= |(((irq_status_r & ~clr_bits) | evt) & irq_mask_r);
        fast_mode_lock <= fast_locked;
        boot_area_lock <= boot_locked;
    end
end

// ==========================================================================
// Read path
reg [31:0] rd_word;

// Key registers are write-only and read as zero
always @* begin
    rd_word = 32'h00000000;
    case (s_axi_araddr)
        `OFS_OPTION_BYTE_STATUS: rd_word = {`OBS_RESERVED_HI,
                                 user_byte_high_r, user_byte_low_r,
                                 `OBS_FIXED_ONES,
                                 boot_from_user_r, reset_delay_r,
                                 standby_entry_reset_ctl_r,
                                 `OBS_RESERVED_MID,
                                 read_protect_active_r,
                                 option_complement_error_r};
        `OFS_WRITE_PROTECT_STAT: rd_word[MAP_WIDTH-1:0] = region_protect_map_r;
        `OFS_LOCK_STATUS:        rd_word[3:0] = {boot_dead, fast_dead,
                                                 boot_locked, fast_locked};
        `OFS_IRQ_STATUS:         rd_word[EVT_W-1:0] = irq_status_r;
        `OFS_IRQ_MASK:           rd_word[EVT_W-1:0] = irq_mask_r;
        default:                 rd_word = 32'h00000000;
    endcase
end

// Address taken one cycle, data answered the next
always @(posedge aclk) begin
    if (!aresetn) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b0;
        s_axi_rdata   <= 32'h00000000;
        s_axi_rresp   <= `AXI_OKAY;
    end else begin
        s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
        if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_word;
            case (s_axi_araddr)
                `OFS_OPTION_BYTE_STATUS, `OFS_WRITE_PROTECT_STAT,
                `OFS_FAST_MODE_KEY, `OFS_BOOT_AREA_KEY, `OFS_LOCK_STATUS,
                `OFS_IRQ_STATUS, `OFS_IRQ_MASK: s_axi_rresp <= `AXI_OKAY;
                default:                        s_axi_rresp <= `AXI_SLVERR;
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
end

endmodule

// ===== test/optstat_asserts.sv
// Checker for the option status and unlock key block.
// Assumes binding to the block's top module; sees its ports only.
`timescale 1ns/1ps
`include "optstat_defines.vh"

module optstat_asserts (
    input wire        aclk,
    input wire        aresetn,
    input wire [7:0]  s_axi_araddr,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0]  s_axi_rresp,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready,
    input wire        s_axi_awvalid,
    input wire        s_axi_wvalid,
    input wire [1:0]  s_axi_bresp,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire        fast_mode_lock,
    input wire        boot_area_lock
);
    // ==========================================================
    // Helpers
    reg [7:0] ar_addr_r;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Remember the read address so data can be judged by register
    always @(posedge aclk) begin
        if (s_axi_arvalid && s_axi_arready)
            ar_addr_r <= s_axi_araddr;
    end
    sequence rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence rd_answer;
        s_axi_rvalid;
    endsequence
    // ==========================================================
    // Properties
    locks_reset_a: assert property ($rose(aresetn) |-> fast_mode_lock && boot_area_lock)
        else $error("locks not set after reset");
    unlock_cause_a: assert property ($fell(fast_mode_lock) |->
        $past(s_axi_bvalid, 2) || $past(s_axi_bvalid, 3))
        else $error("fast lock cleared without a write");
    rd_latency_a: assert property (rd_taken |=> rd_answer)
        else $error("read answer late");
    ar_accept_a: assert property (s_axi_arvalid && !s_axi_rvalid |-> ##[0:4] s_axi_arready)
        else $error("read address not taken");
    wr_answer_a: assert property (s_axi_awvalid && s_axi_wvalid |-> ##[1:8] s_axi_bvalid)
        else $error("write response missing");
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    err_rdata_a: assert property (s_axi_rvalid && s_axi_rresp == `AXI_SLVERR |->
        s_axi_rdata == 32'h0)
        else $error("error read with data");
    obs_fixed_a: assert property (s_axi_rvalid && ar_addr_r == `OFS_OPTION_BYTE_STATUS |->
        s_axi_rdata[31:26] == 6'h00 && s_axi_rdata[9:8] == 2'h3)
        else $error("fixed status bits wrong");
    key_wo_a: assert property (s_axi_rvalid && ar_addr_r == `OFS_FAST_MODE_KEY |->
        s_axi_rdata == 32'h0)
        else $error("key register readable");
endmodule

// ===== test/testbench.sv
// Self-checking bench for the option status and unlock key block.
// Assumes the design and its defines header are compiled first.
`timescale 1ns/1ps
`include "optstat_defines.vh"

module testbench;
    // ==========================================================
    // Signals
    reg         aclk = 1'b0;
    reg         aresetn = 1'b0;
    reg  [7:0]  hi = 8'h5a, hi_n = 8'ha5, lo = 8'h3c, lo_n = 8'hc3;
    reg  [7:0]  cfg = 8'hd0, cfg_n = 8'h2f, rdp = 8'ha5, rdp_n = 8'h5a;
    reg  [15:0] map = 16'h12f0, map_n = 16'hed0f;
    reg         fast_relock = 1'b0, boot_relock = 1'b0;
    reg  [7:0]  awaddr = 8'h0, araddr = 8'h0;
    reg         awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    reg         arvalid = 1'b0, rready = 1'b0;
    reg  [31:0] wdata = 32'h0;
    wire        awready, wready, bvalid, arready, rvalid, fml, bal, irq;
    wire [1:0]  bresp, rresp;
    wire [31:0] rdata;
    reg  [31:0] rd;
    reg  [1:0]  rs;
    integer     failures = 0, checks_done = 0;

    flash_option_status_keys #(.MAP_WIDTH(16)) u_flash_option_status_keys (
        .aclk(aclk), .aresetn(aresetn),
        .nv_user_byte_high(hi), .nv_user_byte_high_n(hi_n),
        .nv_user_byte_low(lo), .nv_user_byte_low_n(lo_n),
        .nv_user_cfg(cfg), .nv_user_cfg_n(cfg_n),
        .nv_read_protect(rdp), .nv_read_protect_n(rdp_n),
        .nv_region_map(map), .nv_region_map_n(map_n),
        .fast_relock(fast_relock), .boot_relock(boot_relock),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .fast_mode_lock(fml), .boot_area_lock(bal), .irq(irq));

    initial begin
        forever #2.5 aclk = ~aclk;
    end

    // ==========================================================
    // Tasks
    task check(input [31:0] seen, input [31:0] exp);
        checks_done = checks_done + 1;
        if (seen !== exp) begin
            failures = failures + 1;
            $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Both write channels offered at once, each released when taken
    // A fresh edge first, so no signal is driven twice in one time step
    task wr(input [7:0] a, input [31:0] d);
        reg done;
        done = 1'b0;
        @(posedge aclk);
        awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        while (!done) begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) begin
                rs = bresp; bready <= 1'b0; done = 1'b1;
            end
        end
    endtask
    task rdr(input [7:0] a);
        reg done;
        done = 1'b0;
        @(posedge aclk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        while (!done) begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) begin
                rd = rdata; rs = rresp; rready <= 1'b0; done = 1'b1;
            end
        end
    endtask
    task do_reset;
        aresetn <= 1'b0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        check({fml, bal, irq}, 3'b110);
        repeat (10) @(posedge aclk);
    endtask
    // Expected option status word from the option byte values
    function [31:0] obs(input [7:0] h, input [7:0] l, input [7:0] c, input p, input e);
        obs = {6'h00, h, l, 2'h3, c[7], c[6:5], c[4], 2'h0, p, e};
    endfunction
    task report_and_stop;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge aclk);
        failures = failures + 1;
        report_and_stop;
    end

    // ==========================================================
    // Tests
    initial begin
        do_reset;
        rdr(`OFS_OPTION_BYTE_STATUS);
        check(rd, obs(hi, lo, cfg, 1'b0, 1'b0));
        rdr(`OFS_WRITE_PROTECT_STAT);
        check(rd[15:0], map);
        wr(`OFS_WRITE_PROTECT_STAT, 32'h0000ffff);
        rdr(`OFS_WRITE_PROTECT_STAT);
        check(rd[15:0], map);
        rdr(8'h40);
        check(rs, `AXI_SLVERR);
        wr(8'h40, 32'h1);
        check(rs, `AXI_SLVERR);
        // Unmasked fast unlock raises the interrupt, cleared by W1C
        wr(`OFS_IRQ_MASK, 32'h1f);
        wr(`OFS_FAST_MODE_KEY, `FIRST_UNLOCK_WORD);
        rdr(`OFS_FAST_MODE_KEY);
        check(rd, 32'h0);
        wr(`OFS_FAST_MODE_KEY, `SECOND_UNLOCK_WORD);
        repeat (4) @(posedge aclk);
        check({fml, bal, irq}, 3'b011);
        wr(`OFS_IRQ_STATUS, 32'h1);
        repeat (3) @(posedge aclk);
        check(irq, 1'b0);
        // Masked boot unlock sets status but leaves irq low
        wr(`OFS_IRQ_MASK, 32'h0);
        wr(`OFS_BOOT_AREA_KEY, `FIRST_UNLOCK_WORD);
        wr(`OFS_BOOT_AREA_KEY, `SECOND_UNLOCK_WORD);
        repeat (4) @(posedge aclk);
        check({bal, irq}, 2'b00);
        // Relock, then a broken pair leaves fast mode locked until reset
        fast_relock <= 1'b1;
        boot_relock <= 1'b1;
        @(posedge aclk);
        fast_relock <= 1'b0;
        boot_relock <= 1'b0;
        repeat (3) @(posedge aclk);
        check({fml, bal}, 2'b11);
        wr(`OFS_FAST_MODE_KEY, `FIRST_UNLOCK_WORD);
        wr(`OFS_FAST_MODE_KEY, 32'h11111111);
        wr(`OFS_FAST_MODE_KEY, `FIRST_UNLOCK_WORD);
        wr(`OFS_FAST_MODE_KEY, `SECOND_UNLOCK_WORD);
        repeat (4) @(posedge aclk);
        check(fml, 1'b1);
        rdr(`OFS_LOCK_STATUS);
        check(rd[3:0], 4'h7);
        rdr(`OFS_IRQ_STATUS);
        check(rd, 32'h6);
        // New option bytes, protected and with a bad complement
        cfg <= 8'h20; cfg_n <= 8'hdf; rdp <= 8'h00; rdp_n <= 8'hff; lo_n <= 8'h00;
        do_reset;
        rdr(`OFS_OPTION_BYTE_STATUS);
        check(rd, obs(hi, lo, 8'h20, 1'b1, 1'b1));
        rdr(`OFS_IRQ_STATUS);
        check(rd, 32'h10);
        wr(`OFS_FAST_MODE_KEY, `FIRST_UNLOCK_WORD);
        wr(`OFS_FAST_MODE_KEY, `SECOND_UNLOCK_WORD);
        repeat (4) @(posedge aclk);
        check(fml, 1'b0);
        report_and_stop;
    end
endmodule

bind flash_option_status_keys optstat_asserts u_chk (
    .aclk(aclk), .aresetn(aresetn), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .fast_mode_lock(fast_mode_lock),
    .boot_area_lock(boot_area_lock));
